/* src/anpg_pkg.sv */
// Package for the auto-negotiation partner page register bank.
// Assumes a single 100 MHz clock and an AXI4-Lite master with 32-bit data.
package anpg_pkg;

  // ---------------------------------------------------------------
  // Bus geometry
  // ---------------------------------------------------------------
  localparam int ANPG_ADDR_W = 8;
  localparam int ANPG_DATA_W = 32;
  localparam int ANPG_REG_W = 16;

  // ---------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // ---------------------------------------------------------------
  localparam logic [5:0] ANPG_IDX_PARTNER_BASE = 6'h05;
  localparam logic [5:0] ANPG_IDX_EXPANSION = 6'h06;
  localparam logic [5:0] ANPG_IDX_NP_TRANSMIT = 6'h07;
  localparam logic [5:0] ANPG_IDX_PARTNER_NP = 6'h08;
  localparam logic [5:0] ANPG_IDX_NP_CONTROL = 6'h10;

  // ---------------------------------------------------------------
  // Field positions, masks and reset values
  // ---------------------------------------------------------------
  localparam int ANPG_BIT_MORE_PAGES = 15;
  localparam int ANPG_BIT_SEND_TOGGLE = 11;
  localparam int ANPG_BIT_NP_SELECT = 12;
  localparam int ANPG_EXP_RSVD_W = 11;
  localparam logic [15:0] ANPG_TX_WR_MASK = 16'hb7ff;
  localparam logic [15:0] ANPG_TX_RESET = 16'h2001;
  localparam logic [15:0] ANPG_PAGE_RESET = 16'h0000;
  localparam logic ANPG_LOCAL_NP_CAPABLE = 1'h1;

  // ---------------------------------------------------------------
  // Bus responses
  // ---------------------------------------------------------------
  localparam logic [1:0] ANPG_RESP_OKAY = 2'h0;
  localparam logic [1:0] ANPG_RESP_SLVERR = 2'h2;

  // ---------------------------------------------------------------
  // Bus carriers
  // ---------------------------------------------------------------
  typedef struct packed {
    logic awvalid;
    logic [ANPG_ADDR_W-1:0] awaddr;
    logic wvalid;
    logic [ANPG_DATA_W-1:0] wdata;
    logic [3:0] wstrb;
    logic bready;
    logic arvalid;
    logic [ANPG_ADDR_W-1:0] araddr;
    logic rready;
  } anpg_axi_req_t;

  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [ANPG_DATA_W-1:0] rdata;
    logic [1:0] rresp;
  } anpg_axi_rsp_t;

endpackage : anpg_pkg

/* src/anpg_regs.sv */
// Partner page, expansion and next page transmit registers behind AXI4-Lite.
// Assumes the negotiation engine runs on ref_clk_i and gives one-cycle pulses.
`timescale 1ns/1ps
`default_nettype none

module anpg_regs
  import anpg_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic resetn_i,
  input wire logic soft_reset_i,
  input wire anpg_axi_req_t axi_req_i,
  output anpg_axi_rsp_t axi_rsp_o,
  input wire logic page_rx_valid_i,
  input wire logic page_rx_is_next_i,
  input wire logic [ANPG_REG_W-1:0] page_rx_word_i,
  input wire logic parallel_detect_fault_i,
  input wire logic page_sent_i,
  output logic [ANPG_REG_W-1:0] tx_page_o,
  output logic next_page_loaded_o,
  output logic np_store_select_o
);

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  typedef struct packed {
    logic aw_have;
    logic [ANPG_ADDR_W-1:0] aw_addr;
    logic w_have;
    logic [ANPG_DATA_W-1:0] w_data;
    logic [3:0] w_strb;
    anpg_axi_rsp_t rsp;
    logic [ANPG_REG_W-1:0] base_pg;
    logic [ANPG_REG_W-1:0] next_pg;
    logic par_fault;
    logic new_page;
    logic partner_np;
    logic partner_an;
    logic [ANPG_REG_W-1:0] tx_pg;
    logic np_sel;
    logic np_loaded;
  } anpg_state_t;

  localparam anpg_state_t ANPG_STATE_RESET = '{
    aw_addr: '0, w_data: '0, w_strb: '0, rsp: '0,
    base_pg: ANPG_PAGE_RESET, next_pg: ANPG_PAGE_RESET, tx_pg: ANPG_TX_RESET,
    default: 1'b0
  };

  anpg_state_t q, d;
  logic wr_fire;
  logic rd_fire;
  logic [5:0] wr_idx;
  logic [5:0] rd_idx;
  logic [ANPG_REG_W-1:0] lane_mask;
  logic [ANPG_REG_W-1:0] exp_view;

  // ---------------------------------------------------------------
  // Decode helpers
  // ---------------------------------------------------------------
  // Word index from byte address, byte lane mask, expansion view
  assign wr_idx = q.aw_addr[7:2];
  assign rd_idx = axi_req_i.araddr[7:2];
  assign wr_fire = q.aw_have && q.w_have && !q.rsp.bvalid;
  assign rd_fire = axi_req_i.arvalid && q.rsp.arready;
  assign lane_mask = {{8{q.w_strb[1]}}, {8{q.w_strb[0]}}};
  assign exp_view = {{ANPG_EXP_RSVD_W{1'b0}}, q.par_fault, q.partner_np, ANPG_LOCAL_NP_CAPABLE,
                     q.new_page, q.partner_an};

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  // Bus handshakes, register writes, page capture and latched flags
  always_comb begin
    d = q;
    d.np_loaded = 1'b0;

    // Write address and data taken in either order
    if (axi_req_i.awvalid && q.rsp.awready) begin
      d.aw_have = 1'b1;
      d.aw_addr = axi_req_i.awaddr;
    end
    if (axi_req_i.wvalid && q.rsp.wready) begin
      d.w_have = 1'b1;
      d.w_data = axi_req_i.wdata;
      d.w_strb = axi_req_i.wstrb;
    end
    d.rsp.awready = !d.aw_have && !q.rsp.bvalid;
    d.rsp.wready = !d.w_have && !q.rsp.bvalid;

    // Read address open while no read answer stands
    d.rsp.arready = !q.rsp.rvalid;

    // Write response ends once the master accepts it
    if (q.rsp.bvalid && axi_req_i.bready) begin
      d.rsp.bvalid = 1'b0;
      d.rsp.awready = 1'b1;
      d.rsp.wready = 1'b1;
    end

    // Read response ends once the master accepts it
    if (q.rsp.rvalid && axi_req_i.rready) begin
      d.rsp.rvalid = 1'b0;
      d.rsp.arready = 1'b1;
    end

    // Latched flags clear on an expansion read
    if (rd_fire) begin
      d.rsp.arready = 1'b0;
      d.rsp.rvalid = 1'b1;
      d.rsp.rresp = ANPG_RESP_OKAY;
      d.rsp.rdata = '0;
      if (rd_idx == ANPG_IDX_PARTNER_BASE) begin
        d.rsp.rdata[ANPG_REG_W-1:0] = q.base_pg;
      end else if (rd_idx == ANPG_IDX_EXPANSION) begin
        d.rsp.rdata[ANPG_REG_W-1:0] = exp_view;
        d.par_fault = 1'b0;
        d.new_page = 1'b0;
      end else if (rd_idx == ANPG_IDX_NP_TRANSMIT) begin
        d.rsp.rdata[ANPG_REG_W-1:0] = q.tx_pg;
      end else if (rd_idx == ANPG_IDX_PARTNER_NP) begin
        d.rsp.rdata[ANPG_REG_W-1:0] = q.next_pg;
      end else if (rd_idx == ANPG_IDX_NP_CONTROL) begin
        d.rsp.rdata[ANPG_BIT_NP_SELECT] = q.np_sel;
      end else begin
        d.rsp.rresp = ANPG_RESP_SLVERR;
      end
    end

    // Register write once both halves are held
    if (wr_fire) begin
      d.aw_have = 1'b0;
      d.w_have = 1'b0;
      d.rsp.bvalid = 1'b1;
      d.rsp.bresp = ANPG_RESP_OKAY;
      if (wr_idx == ANPG_IDX_NP_TRANSMIT) begin
        d.tx_pg = (q.tx_pg & ~(ANPG_TX_WR_MASK & lane_mask)) |
                  (q.w_data[ANPG_REG_W-1:0] & ANPG_TX_WR_MASK & lane_mask);
        d.np_loaded = 1'b1;
      end else if (wr_idx == ANPG_IDX_NP_CONTROL) begin
        if (q.w_strb[1]) begin
          d.np_sel = q.w_data[ANPG_BIT_NP_SELECT];
        end
      end else if (wr_idx == ANPG_IDX_PARTNER_BASE || wr_idx == ANPG_IDX_EXPANSION ||
                   wr_idx == ANPG_IDX_PARTNER_NP) begin
        d.rsp.bresp = ANPG_RESP_OKAY; // Read-only, write ignored
      end else begin
        d.rsp.bresp = ANPG_RESP_SLVERR;
      end
    end

    // Engine flips toggle per transmitted next page
    if (page_sent_i) begin
      d.tx_pg[ANPG_BIT_SEND_TOGGLE] = !q.tx_pg[ANPG_BIT_SEND_TOGGLE];
    end

    // Received page capture; set wins over read clear
    if (page_rx_valid_i) begin
      d.new_page = 1'b1;
      if (!page_rx_is_next_i) begin
        d.base_pg = page_rx_word_i;
        d.partner_np = page_rx_word_i[ANPG_BIT_MORE_PAGES];
        d.partner_an = 1'b1;
      end else if (q.np_sel) begin
        d.next_pg = page_rx_word_i;
      end else begin
        d.base_pg = page_rx_word_i;
      end
    end
    if (parallel_detect_fault_i) begin
      d.par_fault = 1'b1;
    end

    // Separate next page store held clear while unselected
    if (!d.np_sel) begin
      d.next_pg = '0;
    end

    // Software reset returns register fields to reset values
    if (soft_reset_i) begin
      d.base_pg = ANPG_STATE_RESET.base_pg;
      d.next_pg = ANPG_STATE_RESET.next_pg;
      d.tx_pg = ANPG_STATE_RESET.tx_pg;
      d.par_fault = 1'b0;
      d.new_page = 1'b0;
      d.partner_np = 1'b0;
      d.partner_an = 1'b0;
      d.np_sel = 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // State register
  // ---------------------------------------------------------------
  // Ready lines come up after reset release
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      q <= ANPG_STATE_RESET;
    end else begin
      q <= d;
    end
  end

  // Outputs straight from state
  assign axi_rsp_o = q.rsp;
  assign tx_page_o = q.tx_pg;
  assign next_page_loaded_o = q.np_loaded;
  assign np_store_select_o = q.np_sel;

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  a_np_overwrite_base: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    page_rx_valid_i && page_rx_is_next_i && !q.np_sel && !soft_reset_i |=> q.base_pg == $past(page_rx_word_i))
    else $error("next page did not overwrite base page");

  a_np_separate_store: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    page_rx_valid_i && page_rx_is_next_i && q.np_sel && !soft_reset_i && !wr_fire
    |=> q.next_pg == $past(page_rx_word_i) && $stable(q.base_pg))
    else $error("next page not stored separately");

  a_base_capture: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    page_rx_valid_i && !page_rx_is_next_i && !soft_reset_i
    |=> q.base_pg == $past(page_rx_word_i) && q.partner_an)
    else $error("base page not captured");

  a_partner_np_flag: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    page_rx_valid_i && !page_rx_is_next_i && !soft_reset_i
    |=> q.partner_np == $past(page_rx_word_i[ANPG_BIT_MORE_PAGES]))
    else $error("partner next page ability wrong");

  a_fault_latch: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    parallel_detect_fault_i && !soft_reset_i |=> q.par_fault [*1] ##1 (q.par_fault || $past(rd_fire)))
    else $error("fault flag did not latch");

  a_new_page_latch: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    page_rx_valid_i && !soft_reset_i |=> q.new_page)
    else $error("page received flag did not latch");

  a_lh_read_clear: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    rd_fire && rd_idx == ANPG_IDX_EXPANSION && !page_rx_valid_i && !parallel_detect_fault_i
    |=> !q.new_page && !q.par_fault && q.rsp.rvalid)
    else $error("latched flags not cleared by read");

  a_exp_read_view: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    rd_fire && rd_idx == ANPG_IDX_EXPANSION
    |=> q.rsp.rdata[2] && q.rsp.rdata[31:5] == '0 && q.rsp.rdata[1] == $past(q.new_page))
    else $error("expansion read value wrong");

  a_np_loaded_pulse: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    wr_fire && wr_idx == ANPG_IDX_NP_TRANSMIT |=> next_page_loaded_o ##1 !next_page_loaded_o)
    else $error("next page loaded pulse missing");

  a_tx_ack_zero: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    !q.tx_pg[14])
    else $error("transmit bit 14 not zero");

  a_tx_toggle_ro: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    wr_fire && !page_sent_i && !soft_reset_i |=> $stable(q.tx_pg[ANPG_BIT_SEND_TOGGLE]))
    else $error("transmit toggle changed by a write");

  a_tx_write_mask: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    wr_fire && wr_idx == ANPG_IDX_NP_TRANSMIT && q.w_strb[1:0] == 2'h3 && !soft_reset_i
    |=> (q.tx_pg & ANPG_TX_WR_MASK) == ($past(q.w_data[ANPG_REG_W-1:0]) & ANPG_TX_WR_MASK))
    else $error("transmit writable bits wrong");

  a_np_clear_unsel: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    !q.np_sel |-> q.next_pg == '0)
    else $error("partner next page not clear");

  a_toggle_flip: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    page_sent_i && !soft_reset_i |=> q.tx_pg[ANPG_BIT_SEND_TOGGLE] != $past(q.tx_pg[ANPG_BIT_SEND_TOGGLE]))
    else $error("toggle did not invert");

  a_np_sel_write: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    wr_fire && wr_idx == ANPG_IDX_NP_CONTROL && q.w_strb[1] && !soft_reset_i
    |=> q.np_sel == $past(q.w_data[ANPG_BIT_NP_SELECT]))
    else $error("store select not written");

  a_ack_copy: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    page_rx_valid_i && !(page_rx_is_next_i && q.np_sel) && !soft_reset_i
    |=> q.base_pg[14] == $past(page_rx_word_i[14]))
    else $error("received ack bit not kept");

  a_soft_reset_vals: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    soft_reset_i |=> q.tx_pg == ANPG_TX_RESET && q.base_pg == ANPG_PAGE_RESET && !q.np_sel && !q.new_page)
    else $error("software reset values wrong");

endmodule : anpg_regs
`default_nettype wire

/* dv/anpg_engine_model.sv */
// Behavioural negotiation engine that feeds the register bank.
// Assumes the bench calls its tasks right after a rising clock edge.
`timescale 1ns/1ps
`default_nettype none
module anpg_engine_model
  import anpg_pkg::*;
(
  input wire logic ref_clk_i,
  output logic page_rx_valid_o,
  output logic page_rx_is_next_o,
  output logic [ANPG_REG_W-1:0] page_rx_word_o,
  output logic parallel_detect_fault_o,
  output logic page_sent_o
);
  // Idle lines at time zero
  initial begin
    page_rx_valid_o = 1'b0;
    page_rx_is_next_o = 1'b0;
    page_rx_word_o = 16'h0000;
    parallel_detect_fault_o = 1'b0;
    page_sent_o = 1'b0;
  end

  // One-cycle page strobe; a stale word shows its inverse
  task automatic send_page(input logic [15:0] w, input logic nxt);
    @(posedge ref_clk_i);
    page_rx_valid_o <= 1'b1;
    page_rx_is_next_o <= nxt;
    page_rx_word_o <= w;
    @(posedge ref_clk_i);
    page_rx_valid_o <= 1'b0;
    page_rx_is_next_o <= ~nxt;
    page_rx_word_o <= ~w;
  endtask : send_page

  // One-cycle fault or page-sent strobe
  task automatic strobe(input logic f, input logic s);
    @(posedge ref_clk_i);
    parallel_detect_fault_o <= f;
    page_sent_o <= s;
    @(posedge ref_clk_i);
    parallel_detect_fault_o <= 1'b0;
    page_sent_o <= 1'b0;
  endtask : strobe
endmodule : anpg_engine_model
`default_nettype wire

/* dv/anpg_regs_tb_top.sv */
// Self-checking bench for the partner page register bank.
// Assumes the engine model and an AXI4-Lite master built here.
`timescale 1ns/1ps
`default_nettype none
module anpg_regs_tb_top
  import anpg_pkg::*;
();
  logic ref_clk_i, resetn_i, soft_reset_i, pv, pn, pf, ps, loaded, sel;
  logic [15:0] pw, txp;
  anpg_axi_req_t req;
  anpg_axi_rsp_t rsp;
  int n_mismatch = 0;
  int n_checks = 0;
  int cyc = 0;

  // 100 MHz clock
  initial begin
    ref_clk_i = 1'b0;
    forever #5 ref_clk_i = ~ref_clk_i;
  end

  anpg_engine_model eng (.ref_clk_i(ref_clk_i), .page_rx_valid_o(pv), .page_rx_is_next_o(pn),
    .page_rx_word_o(pw), .parallel_detect_fault_o(pf), .page_sent_o(ps));

  anpg_regs dut (.ref_clk_i(ref_clk_i), .resetn_i(resetn_i), .soft_reset_i(soft_reset_i),
    .axi_req_i(req), .axi_rsp_o(rsp), .page_rx_valid_i(pv), .page_rx_is_next_i(pn),
    .page_rx_word_i(pw), .parallel_detect_fault_i(pf), .page_sent_i(ps), .tx_page_o(txp),
    .next_page_loaded_o(loaded), .np_store_select_o(sel));

  // Compare and count
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask : check

  // Bus write, response code and loaded pulse checked
  task automatic wr(input logic [5:0] idx, input logic [15:0] d, input logic [1:0] er);
    logic aw, w, b, l;
    logic [1:0] r;
    b = 1'b0;
    @(posedge ref_clk_i);
    req.awvalid <= 1'b1;
    req.awaddr <= {idx, 2'b00};
    req.wvalid <= 1'b1;
    req.wdata <= {16'h0000, d};
    req.wstrb <= 4'hf;
    req.bready <= 1'b1;
    while (!b) begin
      @(negedge ref_clk_i);
      aw = req.awvalid & rsp.awready;
      w = req.wvalid & rsp.wready;
      b = rsp.bvalid;
      r = rsp.bresp;
      l = loaded;
      @(posedge ref_clk_i);
      if (aw) req.awvalid <= 1'b0;
      if (w) req.wvalid <= 1'b0;
    end
    req.bready <= 1'b0;
    check({30'h0, r}, {30'h0, er});
    check({31'h0, l}, {31'h0, idx == 6'h07});
  endtask : wr

  // Bus read, data and response code checked
  task automatic rd(input logic [5:0] idx, input logic [15:0] e, input logic [1:0] er);
    logic a, v;
    logic [31:0] d;
    logic [1:0] r;
    v = 1'b0;
    @(posedge ref_clk_i);
    req.arvalid <= 1'b1;
    req.araddr <= {idx, 2'b00};
    req.rready <= 1'b1;
    while (!v) begin
      @(negedge ref_clk_i);
      a = req.arvalid & rsp.arready;
      v = rsp.rvalid;
      d = rsp.rdata;
      r = rsp.rresp;
      @(posedge ref_clk_i);
      if (a) req.arvalid <= 1'b0;
    end
    req.rready <= 1'b0;
    check(d, {16'h0000, e});
    check({30'h0, r}, {30'h0, er});
  endtask : rd

  // Report and end the run
  task automatic print_verdict();
    $display("checks %0d, mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : print_verdict

  // Hang guard
  always @(posedge ref_clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_mismatch++;
      print_verdict();
    end
  end

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    resetn_i = 1'b0;
    soft_reset_i = 1'b0;
    req = '0;
    repeat (16) @(posedge ref_clk_i);
    resetn_i <= 1'b1;
    repeat (2) @(posedge ref_clk_i);
    rd(6'h05, 16'h0000, ANPG_RESP_OKAY);
    rd(6'h06, 16'h0004, ANPG_RESP_OKAY);
    rd(6'h07, 16'h2001, ANPG_RESP_OKAY);
    rd(6'h08, 16'h0000, ANPG_RESP_OKAY);
    rd(6'h03, 16'h0000, ANPG_RESP_SLVERR);
    wr(6'h03, 16'hffff, ANPG_RESP_SLVERR);
    // Transmit page masks and toggle
    wr(6'h07, 16'hffff, ANPG_RESP_OKAY);
    check({16'h0, txp}, 32'h0000b7ff);
    eng.strobe(1'b0, 1'b1);
    rd(6'h07, 16'hbfff, ANPG_RESP_OKAY);
    // Base page, then next page into the same view
    eng.send_page(16'hc3e1, 1'b0);
    rd(6'h05, 16'hc3e1, ANPG_RESP_OKAY);
    rd(6'h06, 16'h000f, ANPG_RESP_OKAY);
    rd(6'h06, 16'h000d, ANPG_RESP_OKAY);
    wr(6'h05, 16'h0000, ANPG_RESP_OKAY);
    eng.send_page(16'h5a5a, 1'b1);
    rd(6'h05, 16'h5a5a, ANPG_RESP_OKAY);
    rd(6'h08, 16'h0000, ANPG_RESP_OKAY);
    // Separate next page storage
    wr(6'h10, 16'h1000, ANPG_RESP_OKAY);
    check({31'h0, sel}, 32'h00000001);
    eng.send_page(16'h0123, 1'b0);
    eng.send_page(16'h6789, 1'b1);
    rd(6'h05, 16'h0123, ANPG_RESP_OKAY);
    rd(6'h08, 16'h6789, ANPG_RESP_OKAY);
    rd(6'h06, 16'h0007, ANPG_RESP_OKAY);
    wr(6'h10, 16'h0000, ANPG_RESP_OKAY);
    check({31'h0, sel}, 32'h00000000);
    rd(6'h08, 16'h0000, ANPG_RESP_OKAY);
    // Parallel detection fault latches until read
    eng.strobe(1'b1, 1'b0);
    rd(6'h06, 16'h0015, ANPG_RESP_OKAY);
    rd(6'h06, 16'h0005, ANPG_RESP_OKAY);
    wr(6'h10, 16'h1000, ANPG_RESP_OKAY);
    rd(6'h10, 16'h1000, ANPG_RESP_OKAY);
    // Software reset restores reset values
    soft_reset_i <= 1'b1;
    @(posedge ref_clk_i);
    soft_reset_i <= 1'b0;
    @(posedge ref_clk_i);
    rd(6'h07, 16'h2001, ANPG_RESP_OKAY);
    rd(6'h05, 16'h0000, ANPG_RESP_OKAY);
    rd(6'h06, 16'h0004, ANPG_RESP_OKAY);
    rd(6'h10, 16'h0000, ANPG_RESP_OKAY);
    check({31'h0, sel}, 32'h00000000);
    check({16'h0, txp}, 32'h00002001);
    print_verdict();
  end
endmodule : anpg_regs_tb_top
`default_nettype wire
